// ### hw/caec_top.sv
// event selection and counting for the coherence agent monitor
// Contract
// - code 0x57 counts agent transactions sent around the home pipe
// - bypass mask bit 0 counts full bypasses taken
// - bypass mask bit 1 counts intermediate bypasses taken
// - bypass mask bit 2 counts misses that issued a memory read only
// - code 0x00 adds at most one per clock, on counters 0 to 3
// - code 0x33 counts cross snoops by target count and originator
// - snoop decision from opcode and presence bits; two-bit shared read skips
// - single presence bit may be modified; ownership read invalidates cores
// - snoop mask upper nibble picks originator, lower nibble target count
// - all four originator bits count from any originator
// - multi-target far socket resolved to upper nibble 0001
// - code 0x1f adds occupancy, up to 20 per cycle, on any counter, filtered by counter 0 settings
// - occupancy filtered by threshold, invert and edge detect
// - reads issued plus full bypasses equals memory read commands
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module caec_top (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // bypass pulses
   input  wire logic        bypass_full,
   input  wire logic        bypass_mid,
   input  wire logic        bypass_miss,
   input  wire logic        bypass_miss_rd,
   // memory reads issued (normal, priority)
   input  wire logic [1:0]  mem_read_issue,
   // cache lookup for snoop decision
   input  wire logic        lookup_valid,
   input  wire logic        lookup_is_read,
   input  wire logic        lookup_is_own,
   input  wire logic [3:0]  lookup_origin,
   input  wire logic [7:0]  core_presence_bits,
   // queue occupancy and direct completion pulses
   input  wire logic [4:0]  queue_occupancy,
   input  wire logic [2:0]  direct_completion_event,
   input  wire logic [7:0]  direct_completion_opcode_event,
   // snoop decision out
   output logic             snoop_cores,
   output logic             snoop_invalidate
);

   logic [31:0] ctrl [caec_pkg::NUM_CNT];
   logic [31:0] cnt  [caec_pkg::NUM_CNT];
   logic [31:0] mem_reads_issued_event;
   logic [31:0] fill_last;
   logic        occ_prev;

   // snoop decision
   wire [3:0] pres_cnt = 4'($countones(core_presence_bits));
   wire       one_core = (pres_cnt == 4'h1);
   wire       want_snp = lookup_valid && (pres_cnt != 4'h0)
                         && (lookup_is_own || one_core);
   wire       multi_tgt = (pres_cnt > 4'h1);

   // occupancy filter
   wire [7:0] thr0     = ctrl[0][caec_pkg::THR_LSB +: 8];
   wire       occ_ge   = ({3'h0, queue_occupancy} >= thr0);
   wire       occ_cond = occ_ge ^ ctrl[0][caec_pkg::INV_BIT];
   wire [4:0] occ_raw  = (queue_occupancy > caec_pkg::OCC_MAX) ? caec_pkg::OCC_MAX
                         : queue_occupancy;
   wire [4:0] occ_inc  = (thr0 == 8'h00) ? occ_raw
                         : ctrl[0][caec_pkg::EDGE_BIT] ? {4'h0, occ_cond && !occ_prev}
                         : {4'h0, occ_cond};

   // per counter increment
   logic [4:0] inc [caec_pkg::NUM_CNT];
   genvar gi;
   generate
      for (gi = 0; gi < caec_pkg::NUM_CNT; gi++) begin : g_cnt
         wire [7:0] code = ctrl[gi][caec_pkg::CODE_LSB +: 8];
         wire [7:0] msk  = ctrl[gi][caec_pkg::MASK_LSB +: 8];
         wire by_hit = (msk[0] && bypass_full) || (msk[1] && bypass_mid)
                       || (msk[2] && bypass_miss && bypass_miss_rd);
         wire sn_org = |(msk[7:4] & lookup_origin);
         wire sn_hit = want_snp && sn_org
                       && ((msk[0] && !multi_tgt) || (msk[1] && multi_tgt));
         wire rd_hit = |(msk[1:0] & mem_read_issue);
         wire dc_hit = |(msk[2:0] & direct_completion_event);
         wire do_hit = |(msk & direct_completion_opcode_event);
         always_comb begin
            unique case (code)
               caec_pkg::EV_TICKS:  inc[gi] = 5'h01;
               caec_pkg::EV_BYPASS: inc[gi] = {4'h0, by_hit};
               caec_pkg::EV_SNOOP:  inc[gi] = {4'h0, sn_hit};
               caec_pkg::EV_FILL:   inc[gi] = occ_inc;
               caec_pkg::EV_READS:  inc[gi] = {4'h0, rd_hit};
               caec_pkg::EV_DC:     inc[gi] = {4'h0, dc_hit};
               caec_pkg::EV_DCOPC:  inc[gi] = {4'h0, do_hit};
               default:             inc[gi] = 5'h00;
            endcase
         end
      end
   endgenerate

   // axi4-lite write side
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   wire        aw_now  = s_axi_awvalid && s_axi_awready;
   wire        w_now   = s_axi_wvalid && s_axi_wready;
   wire        aw_have = aw_held || aw_now;
   wire        w_have  = w_held || w_now;
   wire        do_wr   = aw_have && w_have;
   wire [7:0]  wa      = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd      = w_held ? w_data : s_axi_wdata;
   wire [3:0]  ws      = w_held ? w_strb : s_axi_wstrb;
   wire        wa_ctrl = (wa[7:4] == 4'h0) && (wa[1:0] == 2'h0);
   wire        wa_cnt  = (wa[7:4] == 4'h1) && (wa[1:0] == 2'h0);
   wire [1:0]  wa_idx  = wa[3:2];
   wire [31:0] wmask   = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= caec_pkg::RESP_OKAY;
      end else begin
         if (aw_now) aw_addr <= s_axi_awaddr;
         if (w_now) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         aw_held <= do_wr ? 1'b0 : aw_have;
         w_held  <= do_wr ? 1'b0 : w_have;
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wa_ctrl || wa_cnt) ? caec_pkg::RESP_OKAY : caec_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control and counters
   integer i;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < caec_pkg::NUM_CNT; i++) begin
            ctrl[i] <= caec_pkg::CTRL_RST;
            cnt[i]  <= caec_pkg::CNT_RST;
         end
      end else begin
         for (i = 0; i < caec_pkg::NUM_CNT; i++) begin
            if (do_wr && wa_ctrl && (wa_idx == 2'(i)))
               ctrl[i] <= (ctrl[i] & ~wmask) | (wd & wmask);
            if (do_wr && wa_cnt && (wa_idx == 2'(i)))
               cnt[i] <= (cnt[i] & ~wmask) | (wd & wmask);
            else if (ctrl[i][caec_pkg::EN_BIT])
               cnt[i] <= cnt[i] + {27'h0, inc[i]};
         end
      end
   end

   // check total, fill sample and snoop outputs
   wire [1:0] rd_sum = {1'b0, mem_read_issue[0]} + {1'b0, mem_read_issue[1]}
                       + {1'b0, bypass_full};
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mem_reads_issued_event <= 32'h0000_0000;
         fill_last              <= 32'h0000_0000;
         occ_prev               <= 1'b0;
         snoop_cores            <= 1'b0;
         snoop_invalidate       <= 1'b0;
      end else begin
         mem_reads_issued_event <= mem_reads_issued_event + {30'h0, rd_sum};
         fill_last              <= {27'h0, occ_raw};
         occ_prev               <= occ_cond;
         snoop_cores            <= want_snp;
         snoop_invalidate       <= want_snp && lookup_is_own;
      end
   end

   // axi4-lite read side
   wire        rd_take = s_axi_arvalid && s_axi_arready;
   wire [7:0]  ra      = s_axi_araddr;
   wire        ra_ok   = (ra <= caec_pkg::OCC_OFF) && (ra[1:0] == 2'h0);
   wire [31:0] rsel    = (ra[7:4] == 4'h0) ? ctrl[ra[3:2]]
                       : (ra[7:4] == 4'h1) ? cnt[ra[3:2]]
                       : (ra == caec_pkg::CHECK_OFF) ? mem_reads_issued_event
                       : fill_last;
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= caec_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= ra_ok ? rsel : 32'h0000_0000;
         s_axi_rresp  <= ra_ok ? caec_pkg::RESP_OKAY : caec_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // assertions
   property p_ticks_one;
      @(posedge core_clk) disable iff (rst)
      (ctrl[1][7:0] == caec_pkg::EV_TICKS) && ctrl[1][caec_pkg::EN_BIT] && !do_wr
      |=> (cnt[1] == $past(cnt[1]) + 32'h1);
   endproperty
   a_ticks_one: assert property (p_ticks_one) else $error("tick count wrong");

   property p_bypass_full;
      @(posedge core_clk) disable iff (rst)
      (ctrl[2][7:0] == caec_pkg::EV_BYPASS) && ctrl[2][caec_pkg::EN_BIT] && !do_wr
      && ctrl[2][8] && bypass_full |=> (cnt[2] == $past(cnt[2]) + 32'h1);
   endproperty
   a_bypass_full: assert property (p_bypass_full) else $error("bypass missed");

   property p_bypass_mid;
      @(posedge core_clk) disable iff (rst)
      (ctrl[2][7:0] == caec_pkg::EV_BYPASS) && ctrl[2][caec_pkg::MASK_LSB + 1]
      && bypass_mid |-> (inc[2] == 5'h01);
   endproperty
   a_bypass_mid: assert property (p_bypass_mid) else $error("mid bypass missed");

   property p_bypass_nord;
      @(posedge core_clk) disable iff (rst)
      (ctrl[2][15:8] == 8'h04) && (ctrl[2][7:0] == caec_pkg::EV_BYPASS)
      && !bypass_miss_rd |-> (inc[2] == 5'h00);
   endproperty
   a_bypass_nord: assert property (p_bypass_nord) else $error("miss without read");

   property p_shared_read;
      @(posedge core_clk) disable iff (rst)
      lookup_valid && lookup_is_read && !lookup_is_own && (pres_cnt == 4'h2) |=> !snoop_cores;
   endproperty
   a_shared_read: assert property (p_shared_read) else $error("shared read snooped");

   property p_own_inv;
      @(posedge core_clk) disable iff (rst)
      lookup_valid && lookup_is_own && (pres_cnt != 4'h0) |=> snoop_invalidate;
   endproperty
   a_own_inv: assert property (p_own_inv) else $error("ownership no inval");

   property p_snoop_origin;
      @(posedge core_clk) disable iff (rst)
      (ctrl[3][7:0] == caec_pkg::EV_SNOOP) && !(|(ctrl[3][15:12] & lookup_origin))
      |-> (inc[3] == 5'h00);
   endproperty
   a_snoop_origin: assert property (p_snoop_origin) else $error("wrong origin");

   property p_snoop_multi;
      @(posedge core_clk) disable iff (rst)
      (ctrl[3][7:0] == caec_pkg::EV_SNOOP) && (ctrl[3][15:8] == 8'hF2) && lookup_valid
      && lookup_is_own && (lookup_origin != 4'h0)
      && (pres_cnt > 4'h1) |-> (inc[3] == 5'h01);
   endproperty
   a_snoop_multi: assert property (p_snoop_multi) else $error("multi snoop missed");

   property p_fill_cap;
      @(posedge core_clk) disable iff (rst)
      1'b1 |-> (inc[0] <= caec_pkg::OCC_MAX);
   endproperty
   a_fill_cap: assert property (p_fill_cap) else $error("over twenty");

   property p_edge_once;
      @(posedge core_clk) disable iff (rst)
      (ctrl[0][7:0] == caec_pkg::EV_FILL) && ctrl[0][caec_pkg::EDGE_BIT]
      && (thr0 != 8'h00) && occ_prev |-> (inc[0] == 5'h00);
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("edge counted twice");

   property p_check_sum;
      @(posedge core_clk) disable iff (rst)
      bypass_full && (mem_read_issue == 2'h0)
      |=> (mem_reads_issued_event == $past(mem_reads_issued_event) + 32'h1);
   endproperty
   a_check_sum: assert property (p_check_sum) else $error("sum mismatch");

   c_write: cover property (@(posedge core_clk) disable iff (rst) do_wr);
   c_read: cover property (@(posedge core_clk) disable iff (rst) rd_take);
   c_snoop: cover property (@(posedge core_clk) disable iff (rst) snoop_invalidate);
   c_fill_edge: cover property (@(posedge core_clk) disable iff (rst) occ_cond && !occ_prev);
   c_no_snoop: cover property (@(posedge core_clk) disable iff (rst) lookup_valid && !want_snp);
endmodule

// ### inc/caec_pkg.sv
// constants for the coherence agent event counting block
package caec_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL0_OFF  = 8'h00;
   localparam logic [7:0] CTRL1_OFF  = 8'h04;
   localparam logic [7:0] CTRL2_OFF  = 8'h08;
   localparam logic [7:0] CTRL3_OFF  = 8'h0C;
   localparam logic [7:0] CNT0_OFF   = 8'h10;
   localparam logic [7:0] CNT1_OFF   = 8'h14;
   localparam logic [7:0] CNT2_OFF   = 8'h18;
   localparam logic [7:0] CNT3_OFF   = 8'h1C;
   localparam logic [7:0] CHECK_OFF  = 8'h20;
   localparam logic [7:0] OCC_OFF    = 8'h24;
   // control field positions
   localparam int CODE_LSB   = 0;
   localparam int MASK_LSB   = 8;
   localparam int EDGE_BIT   = 18;
   localparam int EN_BIT     = 22;
   localparam int INV_BIT    = 23;
   localparam int THR_LSB    = 24;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_RST  = 32'h0000_0000;
   // event codes
   localparam logic [7:0] EV_TICKS  = 8'h00;
   localparam logic [7:0] EV_FILL   = 8'h1F;
   localparam logic [7:0] EV_SNOOP  = 8'h33;
   localparam logic [7:0] EV_BYPASS = 8'h57;
   localparam logic [7:0] EV_READS  = 8'h59;
   localparam logic [7:0] EV_DCOPC  = 8'h6D;
   localparam logic [7:0] EV_DC     = 8'h6E;
   // occupancy added per cycle at most
   localparam logic [4:0] OCC_MAX   = 5'h14;
   localparam int NUM_CNT = 4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### testbench/caec_event_src.sv
// behavioural model of the agent pipeline event sources
`timescale 1ns/1ps
module caec_event_src (
   // clock
   input  wire logic  core_clk,
   // pulses and levels towards the counting block
   output logic       bypass_full,
   output logic       bypass_mid,
   output logic       bypass_miss,
   output logic       bypass_miss_rd,
   output logic [1:0] mem_read_issue,
   output logic [2:0] direct_completion_event,
   output logic [7:0] direct_completion_opcode_event,
   output logic [4:0] queue_occupancy,
   output logic       lookup_valid,
   output logic       lookup_is_read,
   output logic       lookup_is_own,
   output logic [3:0] lookup_origin,
   output logic [7:0] core_presence_bits
);
   logic [36:0] v = 37'h0;
   assign {core_presence_bits, lookup_origin, lookup_is_own, lookup_is_read, lookup_valid,
           queue_occupancy, direct_completion_opcode_event, direct_completion_event,
           mem_read_issue, bypass_miss_rd, bypass_miss, bypass_mid, bypass_full} = v;
   // one entry per cycle, then lookup fields go stale-inverted with valid low
   task automatic burst(input logic [36:0] p [4]);
      for (int i = 0; i < 4; i++) begin
         v <= p[i];
         @(posedge core_clk);
      end
      v <= {~v[36:23], 23'h0};
   endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the coherence agent event counting block
`timescale 1ns/1ps
module tb;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, mem_read_issue;
   logic        bypass_full, bypass_mid, bypass_miss, bypass_miss_rd;
   logic        lookup_valid, lookup_is_read, lookup_is_own, snoop_cores, snoop_invalidate;
   logic [3:0]  lookup_origin;
   logic [7:0]  core_presence_bits, direct_completion_opcode_event;
   logic [4:0]  queue_occupancy;
   logic [2:0]  direct_completion_event;
   int          num_errors = 0;
   int          checks = 0;
   int          cyc = 0;

   caec_top caec_top_i (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .bypass_full,
      .bypass_mid, .bypass_miss, .bypass_miss_rd, .mem_read_issue, .lookup_valid,
      .lookup_is_read, .lookup_is_own, .lookup_origin, .core_presence_bits, .queue_occupancy,
      .direct_completion_event, .direct_completion_opcode_event, .snoop_cores,
      .snoop_invalidate);

   caec_event_src caec_event_src_i (.core_clk, .bypass_full, .bypass_mid, .bypass_miss,
      .bypass_miss_rd, .mem_read_issue, .direct_completion_event,
      .direct_completion_opcode_event, .queue_occupancy, .lookup_valid, .lookup_is_read,
      .lookup_is_own, .lookup_origin, .core_presence_bits);

   always #10 core_clk = ~core_clk;

   task automatic conclude();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         $display("wrong value at %0t: run hung", $time);
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, caec_pkg::RESP_OKAY});
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                      output int t);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            t = cyc;
         end
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   function automatic logic [31:0] cw(input logic [7:0] cd, m, th, input logic ed);
      return (32'h1 << caec_pkg::EN_BIT) | (32'(ed) << caec_pkg::EDGE_BIT)
         | (32'(th) << caec_pkg::THR_LSB) | (32'(m) << caec_pkg::MASK_LSB) | 32'(cd);
   endfunction

   function automatic logic [36:0] lk(input logic rd, own, input logic [3:0] o,
                                      input logic [7:0] cp);
      return {cp, o, own, rd, 1'b1, 22'h0};
   endfunction

   function automatic logic [36:0] oc(input logic [4:0] o);
      return {15'h0, o, 17'h0};
   endfunction

   function automatic logic [1:0] snp(input logic [36:0] v);
      logic s;
      s = v[22] && (|v[36:29]) && (v[24] || $countones(v[36:29]) == 1);
      return {s && v[24], s};
   endfunction

   task automatic ev(input int k, input logic [31:0] c, input logic [36:0] p [4],
                     input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      int          t;
      axw(caec_pkg::CTRL0_OFF + 8'(4 * k), c);
      axw(caec_pkg::CNT0_OFF + 8'(4 * k), caec_pkg::CNT_RST);
      caec_event_src_i.burst(p);
      #1;
      chk({30'h0, snoop_invalidate, snoop_cores}, {30'h0, snp(p[3])});
      @(posedge core_clk);
      axr(caec_pkg::CNT0_OFF + 8'(4 * k), d, r, t);
      chk(d, e);
   endtask

   initial begin
      logic [31:0] d, d2;
      logic [1:0]  r;
      int          t, t2;
      logic [7:0]  bm [4] = '{8'h01, 8'h02, 8'h04, 8'h07};
      logic [31:0] be [4] = '{32'h1, 32'h1, 32'h1, 32'h3};
      logic [7:0]  sm [7] = '{8'h41, 8'h21, 8'h12, 8'hF1, 8'hF2, 8'h42, 8'h11};
      logic [31:0] se [7] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h1, 32'h0, 32'h0};
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      axr(caec_pkg::CTRL0_OFF, d, r, t);
      chk(d, caec_pkg::CTRL_RST);
      axr(caec_pkg::CNT3_OFF, d, r, t);
      chk(d, caec_pkg::CNT_RST);
      axr(8'h30, d, r, t);
      chk({r, d[29:0]}, {caec_pkg::RESP_SLVERR, 30'h0});
      for (int k = 0; k < 4; k++) begin
         axw(caec_pkg::CTRL0_OFF + 8'(4 * k), cw(caec_pkg::EV_TICKS, 8'h00, 8'h00, 1'b0));
         axr(caec_pkg::CNT0_OFF + 8'(4 * k), d, r, t);
         repeat (20) @(posedge core_clk);
         axr(caec_pkg::CNT0_OFF + 8'(4 * k), d2, r, t2);
         chk(d2 - d, 32'(t2 - t));
         axw(caec_pkg::CTRL0_OFF + 8'(4 * k), caec_pkg::CTRL_RST);
      end
      foreach (bm[i]) ev(2, cw(caec_pkg::EV_BYPASS, bm[i], 8'h00, 1'b0),
         '{37'h1, 37'h2, 37'h4, 37'hC}, be[i]);
      axr(caec_pkg::CHECK_OFF, d, r, t);
      ev(1, cw(caec_pkg::EV_READS, 8'h01, 8'h00, 1'b0), '{37'h1, 37'h10, 37'h10, 37'h20}, 32'h2);
      axr(caec_pkg::CHECK_OFF, d2, r, t);
      chk(d2 - d, 32'h4);
      ev(2, cw(caec_pkg::EV_DC, 8'h05, 8'h00, 1'b0),
         '{37'h40, 37'h80, 37'h100, 37'h0}, 32'h2);
      ev(3, cw(caec_pkg::EV_DCOPC, 8'h81, 8'h00, 1'b0),
         '{37'h200, 37'h400, 37'h10000, 37'h0}, 32'h2);
      foreach (sm[i]) ev(3, cw(caec_pkg::EV_SNOOP, sm[i], 8'h00, 1'b0),
         '{lk(1'b1, 1'b0, 4'h4, 8'h01), lk(1'b1, 1'b0, 4'h4, 8'h03),
           lk(1'b1, 1'b0, 4'h2, 8'h10), lk(1'b0, 1'b1, 4'h1, 8'h03)},
         se[i]);
      ev(0, cw(caec_pkg::EV_FILL, 8'h00, 8'h00, 1'b0), '{oc(25), oc(7), oc(25), oc(0)},
         2 * 32'(caec_pkg::OCC_MAX) + 32'd7);
      ev(0, cw(caec_pkg::EV_FILL, 8'h00, 8'h01, 1'b0),
         '{oc(3), oc(0), oc(1), oc(31)}, 32'h3);
      ev(0, cw(caec_pkg::EV_FILL, 8'h00, 8'h01, 1'b1),
         '{oc(2), oc(0), oc(2), oc(2)}, 32'h2);
      // inverted: the idle queue adds one just before and one just after the burst
      ev(0, cw(caec_pkg::EV_FILL, 8'h00, 8'h01, 1'b0) | (32'h1 << caec_pkg::INV_BIT),
         '{oc(3), oc(0), oc(1), oc(2)}, 32'h3);
      conclude();
   end
endmodule
